/* File: core/fepc_defines.vh */
/*
  Constants for the flash erase and protection controller: array geometry,
  protection encodings, request codes and the value returned for withheld reads.
  Assumes it is included by bare name from the core files.
*/
//
// Functional notes
// - Array holds 64 KB and every address in that range is decoded.
// - Erase works on 1 KB units, each erased alone.
// - A finished erase leaves every bit of the unit at one.
// - Protection covers pairs of adjacent erase units, 2 KB each.
// - Every 2 KB region has its own read-only and execute-only setting.
// - Erase and program aimed at read-only regions are refused, contents kept.
// - Erase and program aimed at execute-only regions are refused, contents kept.
// - Execute-only data reaches only instruction fetches, never data or debugger reads.
// - Permitted reads finish in one clock cycle.
`ifndef FEPC_DEFINES_VH
`define FEPC_DEFINES_VH

`define FEPC_ADDR_W      16
`define FEPC_WORD_W      32
`define FEPC_WADDR_W     14
`define FEPC_UNIT_LSB    10
`define FEPC_UNIT_W      6
`define FEPC_REGION_LSB  11
`define FEPC_REGION_W    5
`define FEPC_REGIONS     32
`define FEPC_UNIT_WORDS  256
`define FEPC_ERASE_LAST  8'hFF
`define FEPC_PROT_NONE   2'h0
`define FEPC_PROT_RO_BIT 0
`define FEPC_PROT_XO_BIT 1
`define FEPC_MST_FETCH   2'h0
`define FEPC_MST_DATA    2'h1
`define FEPC_MST_DEBUG   2'h2
`define FEPC_ERASED_WORD 32'hFFFFFFFF
`define FEPC_WITHHELD    32'h00000000

`endif

/* File: core/fepc_prot_table.v */
/*
  Per-region protection table: two bits per 2 KB region, read-only and
  execute-only, loaded from a configuration port.
  Assumes a single clock and an asynchronous active-high reset.
*/
`timescale 1ns/10ps
`include "fepc_defines.vh"
module fepc_prot_table #(
  parameter REGIONS = `FEPC_REGIONS
) (
  input  wire                          clk,
  input  wire                          rst,
  input  wire                          cfgWe,
  input  wire [`FEPC_REGION_W-1:0]     cfgRegion,
  input  wire [1:0]                    cfgProt,
  output wire [2*REGIONS-1:0]          protFlat
);
  reg [1:0] prot_r [0:REGIONS-1];
  genvar g;
  generate
    for (g = 0; g < REGIONS; g = g + 1) begin : gReg
      always @(posedge clk or posedge rst) begin
        if (rst) begin
          prot_r[g] <= `FEPC_PROT_NONE;
        end else if (cfgWe && cfgRegion == g) begin
          prot_r[g] <= cfgProt;
        end
      end
      assign protFlat[2*g+1:2*g] = prot_r[g];
    end
  endgenerate
endmodule

/* File: core/fepc_flash_ctrl.v */
/*
  Flash access and erase controller: one read port shared by fetch, data and
  debugger masters, one program/erase request port, per-region protection.
  Assumes requesters are synchronous logic on clk and hold no request longer
  than one cycle; the array is modelled as a register array.
*/
`timescale 1ns/10ps
`include "fepc_defines.vh"
module fepc_flash_ctrl #(
  parameter WORDS = (1 << `FEPC_WADDR_W)
) (
  input  wire                          clk,
  input  wire                          rst,
  input  wire                          rdReq,
  input  wire [1:0]                    rdMaster,
  input  wire [`FEPC_ADDR_W-1:0]       rdAddr,
  input  wire                          progReq,
  input  wire [`FEPC_ADDR_W-1:0]       progAddr,
  input  wire [`FEPC_WORD_W-1:0]       progData,
  input  wire                          eraseReq,
  input  wire [`FEPC_UNIT_W-1:0]       eraseUnit,
  input  wire                          cfgWe,
  input  wire [`FEPC_REGION_W-1:0]     cfgRegion,
  input  wire [1:0]                    cfgProt,
  output reg                           rdValid,
  output reg  [`FEPC_WORD_W-1:0]       rdData,
  output reg                           rdErr,
  output reg                           opDone,
  output reg                           opRefused,
  output reg                           eraseBusy
);
  localparam ST_IDLE  = 2'b01;
  localparam ST_ERASE = 2'b10;

  reg  [`FEPC_WORD_W-1:0]   mem [0:WORDS-1];
  wire [2*`FEPC_REGIONS-1:0] protFlat;
  reg  [1:0]                state_r;
  reg  [1:0]                state_nxt;
  reg  [7:0]                eraseCnt_r;
  reg  [`FEPC_UNIT_W-1:0]   eraseUnit_r;

  fepc_prot_table #(.REGIONS(`FEPC_REGIONS)) uProt (
    .clk       (clk),
    .rst       (rst),
    .cfgWe     (cfgWe),
    .cfgRegion (cfgRegion),
    .cfgProt   (cfgProt),
    .protFlat  (protFlat)
  );

  // Protection bits of the region holding a byte address
  function [1:0] regionProt;
    input [`FEPC_ADDR_W-1:0]     addr;
    input [2*`FEPC_REGIONS-1:0]  flat;
    reg   [`FEPC_REGION_W-1:0]   idx;
    begin
      idx = addr[`FEPC_ADDR_W-1:`FEPC_REGION_LSB];
      regionProt = flat[2*idx +: 2];
    end
  endfunction

  wire [1:0] rdProt   = regionProt(rdAddr, protFlat);
  wire [1:0] progProt = regionProt(progAddr, protFlat);
  wire [1:0] ersProt  = regionProt({eraseUnit, {`FEPC_UNIT_LSB{1'b0}}}, protFlat);
  wire       rdBlock  = rdProt[`FEPC_PROT_XO_BIT] && (rdMaster != `FEPC_MST_FETCH);
  wire       progOk   = (progProt == `FEPC_PROT_NONE);
  wire       ersOk    = (ersProt == `FEPC_PROT_NONE);
  wire       idle     = state_r[0];

  // Reads: one cycle, full 64 KB decoded by word address
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData  <= `FEPC_WITHHELD;
      rdErr   <= 1'b0;
    end else begin
      rdValid <= rdReq;
      rdErr   <= rdReq && rdBlock;
      if (rdReq) begin
        rdData <= rdBlock ? `FEPC_WITHHELD :
                  mem[rdAddr[`FEPC_ADDR_W-1:2]];
      end
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (eraseReq && ersOk) begin
          state_nxt = ST_ERASE;
        end
      end
      ST_ERASE: begin
        if (eraseCnt_r == `FEPC_ERASE_LAST) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r     <= ST_IDLE;
      eraseCnt_r  <= 8'h00;
      eraseUnit_r <= {`FEPC_UNIT_W{1'b0}};
      opDone      <= 1'b0;
      opRefused   <= 1'b0;
      eraseBusy   <= 1'b0;
    end else begin
      state_r   <= state_nxt;
      opDone    <= 1'b0;
      opRefused <= 1'b0;
      eraseBusy <= state_nxt[1];
      if (idle) begin
        if (eraseReq) begin
          opRefused   <= ~ersOk;
          eraseUnit_r <= eraseUnit;
          eraseCnt_r  <= 8'h00;
        end else if (progReq) begin
          opRefused <= ~progOk;
          opDone    <= progOk;
        end
      end else begin
        eraseCnt_r <= eraseCnt_r + 8'h01;
        if (eraseCnt_r == `FEPC_ERASE_LAST) begin
          opDone <= 1'b1;
        end
      end
    end
  end

  // Array writes: programming clears bits only; erase walks one unit
  always @(posedge clk) begin
    if (!rst && idle && !eraseReq && progReq && progOk) begin
      mem[progAddr[`FEPC_ADDR_W-1:2]] <= mem[progAddr[`FEPC_ADDR_W-1:2]] & progData;
    end else if (!rst && !idle) begin
      mem[{eraseUnit_r, eraseCnt_r}] <= `FEPC_ERASED_WORD;
    end
  end
endmodule

/* File: testbench/fepc_flash_ctrl_sva.sv */
/* Port assertions for fepc_flash_ctrl. Assumes a bind to that module. */
`timescale 1ns/10ps
module fepc_chk (
  input wire logic clk, rst, rdReq, progReq, eraseReq, rdValid, rdErr, opDone, opRefused,
  input wire logic eraseBusy, input wire logic [1:0] rdMaster, input wire logic [31:0] rdData);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_late: assert property (rdReq |=> rdValid) else $error("late");
  a_read_stray: assert property (!rdReq |=> !rdValid) else $error("stray");
  a_fetch_ok: assert property (rdReq && rdMaster == 2'h0 |=> !rdErr) else $error("fetch");
  a_zero_out: assert property (rdErr |-> rdData == 32'h0) else $error("leak");
  a_erase_len: assert property ($rose(eraseBusy) |-> ##256 !eraseBusy && opDone)
    else $error("length");
  a_erase_reply: assert property (eraseReq && !eraseBusy |=> eraseBusy != opRefused)
    else $error("erase");
  a_prog_reply: assert property (progReq && !eraseReq && !eraseBusy |=>
    opDone != opRefused) else $error("program");
  a_one_outcome: assert property (!(opDone && opRefused)) else $error("both");
  cover property (rdErr);
  cover property ($rose(eraseBusy));
  cover property (opRefused);
endmodule
bind fepc_flash_ctrl fepc_chk i_fepc_chk (.*);

/* File: testbench/fepc_mst.sv */
/* Model of the reading masters and the programmer. Assumes one clock. */
`timescale 1ns/10ps
module fepc_mst (
  input wire logic clk, rdValid, rdErr, opDone, opRefused, input wire logic [31:0] rdData,
  output logic rdReq, progReq, eraseReq, cfgWe, output logic [1:0] rdMaster, cfgProt,
  output logic [15:0] rdAddr, progAddr, output logic [31:0] progData,
  output logic [5:0] eraseUnit, output logic [4:0] cfgRegion);
  // Unit, region and protection follow the address and data lines
  assign {eraseUnit, cfgRegion, cfgProt} = {progAddr[15:10], progAddr[15:11], progData[1:0]};
  initial {rdReq, progReq, eraseReq, cfgWe, rdMaster, rdAddr, progAddr, progData} = '0;
  task rd(input logic [1:0] m, logic [15:0] a, output logic [33:0] r);
    @(posedge clk) #1 {rdReq, rdMaster, rdAddr} = {1'b1, m, a};
    @(posedge clk) #1 {rdReq, rdAddr} = {1'b0, ~a};
    r = {rdData, rdValid, rdErr};
  endtask
  // Kind 0 programs, 1 erases, 2 sets protection
  task op(input logic [1:0] k, logic [15:0] a, logic [31:0] v, output logic [1:0] f);
    @(posedge clk) #1 {cfgWe, eraseReq, progReq, progAddr, progData} = {k == 2, k == 1, k == 0, a, v};
    @(posedge clk) #1 {cfgWe, eraseReq, progReq, progAddr, progData} = {3'b0, ~a, ~v};
    for (int i = 0; i < 300 && !opDone && !opRefused; i++) @(posedge clk) #1;
    f = {opDone, opRefused};
  endtask
endmodule

/* File: testbench/fepc_flash_ctrl_tb.sv */
/* Bench for fepc_flash_ctrl driven by fepc_mst. Assumes fepc_chk is bound. */
`timescale 1ns/10ps
module fepc_flash_ctrl_tb;
  logic clk, rst, rdReq, progReq, eraseReq, cfgWe, rdValid, rdErr, opDone, opRefused, eraseBusy;
  logic [1:0] rdMaster, cfgProt, f;
  logic [4:0] cfgRegion;
  logic [5:0] eraseUnit;
  logic [15:0] rdAddr, progAddr;
  logic [31:0] progData, rdData;
  logic [33:0] r;
  int fail_count = 0, n_tests = 0;
  fepc_flash_ctrl i_fepc_flash_ctrl (.*);
  fepc_mst i_fepc_mst (.*);
  task chk(input logic [33:0] g, e);
    n_tests++;
    if (g !== e) begin fail_count++; $display("wrong value %0t %h %h", $time, g, e); end
  endtask
  task give_verdict;
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task t_open;
    i_fepc_mst.op(1, 16'h0800, 0, f); chk(f, 2);
    i_fepc_mst.op(0, 16'h0800, 32'hA5A5A5A5, f); chk(f, 2);
    i_fepc_mst.op(1, 16'hFC00, 0, f); chk(f, 2);
    i_fepc_mst.rd(1, 16'hFFFC, r); chk(r, {32'hFFFFFFFF, 2'h2});
    i_fepc_mst.rd(2, 16'h0800, r); chk(r, {32'hA5A5A5A5, 2'h2});
  endtask
  task t_guard;
    i_fepc_mst.op(2, 16'h0800, 2, f);
    i_fepc_mst.op(1, 16'h0800, 0, f); chk(f, 1);
    i_fepc_mst.op(0, 16'h0800, 0, f); chk(f, 1);
    i_fepc_mst.rd(0, 16'h0800, r); chk(r, {32'hA5A5A5A5, 2'h2});
    for (int m = 1; m < 3; m++) begin
      i_fepc_mst.rd(m, 16'h0800, r); chk(r, 3);
    end
    i_fepc_mst.op(2, 16'h0800, 1, f);
    i_fepc_mst.op(1, 16'h0C00, 0, f); chk(f, 1);
    i_fepc_mst.rd(1, 16'h0800, r); chk(r, {32'hA5A5A5A5, 2'h2});
  endtask
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  initial begin
    rst = 1;
    repeat (2) @(posedge clk);
    #1 rst = 0;
    t_open;
    t_guard;
    give_verdict;
  end
  initial begin
    #40000 fail_count++;
    give_verdict;
  end
endmodule
